// File: verilog/cpca_top.v
`timescale 1ns/1ps
`include "cpca_defs.vh"
// ==========================================================
// control port: serial target plus coefficient indirect access
module cpca_top #(
	parameter [15:0] ID_CODE = 16'h5a5a, // arbitrary identification value
	parameter COEF_AW = 7,
	parameter COEF_DW = 20
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// two-wire serial bus, clock comes from the master only
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// codec link register port, same clock domain
	input wire lnk_wr,
	input wire [7:0] lnk_addr,
	input wire [15:0] lnk_wdata,
	output wire [15:0] lnk_rdata,
	// status towards the rest of the chip
	output wire regs_reset,
	output wire coef_busy,
	output wire [2:0] coef_group,
	output wire [1:0] coef_stage,
	output wire [2:0] coef_word
);

// ==========================================================
// states
localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RX = 3'h1;
localparam [2:0] ST_ACK = 3'h2;
localparam [2:0] ST_TX = 3'h3;
localparam [2:0] ST_RACK = 3'h4;

localparam [1:0] PH_SEL = 2'h0;
localparam [1:0] PH_REG = 2'h1;
localparam [1:0] PH_DATA = 2'h2;

localparam [1:0] OP_IDLE = 2'h0;
localparam [1:0] OP_WAIT = 2'h1;
localparam [1:0] OP_CAPT = 2'h2;

// ==========================================================
// input synchronisers
reg scl_m_ff;
reg scl_s_ff;
reg scl_d_ff;
reg sda_m_ff;
reg sda_s_ff;
reg sda_d_ff;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		scl_m_ff <= 1'b1;
		scl_s_ff <= 1'b1;
		scl_d_ff <= 1'b1;
		sda_m_ff <= 1'b1;
		sda_s_ff <= 1'b1;
		sda_d_ff <= 1'b1;
	end else begin
		scl_m_ff <= scl_in;
		scl_s_ff <= scl_m_ff;
		scl_d_ff <= scl_s_ff;
		sda_m_ff <= sda_in;
		sda_s_ff <= sda_m_ff;
		sda_d_ff <= sda_s_ff;
	end
end

wire scl_rise = scl_s_ff & ~scl_d_ff;
wire scl_fall = ~scl_s_ff & scl_d_ff;
// data moving under a high clock is framing, never a data bit
wire bus_start = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
wire bus_stop = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;

// ==========================================================
// register state
reg [15:0] data_low_ff;
reg [15:0] ctrl_ff;
reg [15:0] nxt_data_low;
reg [15:0] nxt_ctrl;
reg regs_reset_ff;
reg [15:0] lnk_rdata_ff;

// byte view of the map, even byte is the high half
function [7:0] map_byte;
	input [7:0] a;
	input [15:0] dl;
	input [15:0] ct;
	begin
		case (a)
		`CPCA_ADDR_RESET_HI: map_byte = ID_CODE[15:8];
		`CPCA_ADDR_RESET_LO: map_byte = ID_CODE[7:0];
		`CPCA_ADDR_DATA_HI: map_byte = dl[15:8];
		`CPCA_ADDR_DATA_LO: map_byte = dl[7:0];
		`CPCA_ADDR_CTRL_HI: map_byte = ct[15:8];
		`CPCA_ADDR_CTRL_LO: map_byte = ct[7:0];
		default: map_byte = 8'h00;
		endcase
	end
endfunction

// ==========================================================
// serial target engine
reg [2:0] st_ff;
reg [1:0] ph_ff;
reg [3:0] cnt_ff;
reg [7:0] shift_ff;
reg [7:0] tx_ff;
reg [7:0] ptr_ff;
reg rd_mode_ff;
reg oe_ff;
reg sda_out_ff;
reg ser_wr_ff;
reg [7:0] ser_waddr_ff;
reg [7:0] ser_wdata_ff;
reg [7:0] ld_byte;

always @* begin
	ld_byte = map_byte(ptr_ff, data_low_ff, ctrl_ff);
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		st_ff <= ST_IDLE;
		ph_ff <= PH_SEL;
		cnt_ff <= 4'h0;
		shift_ff <= 8'h00;
		tx_ff <= 8'h00;
		ptr_ff <= 8'h00;
		rd_mode_ff <= 1'b0;
		oe_ff <= 1'b0;
		sda_out_ff <= 1'b0;
		ser_wr_ff <= 1'b0;
		ser_waddr_ff <= 8'h00;
		ser_wdata_ff <= 8'h00;
	end else begin
		ser_wr_ff <= 1'b0;
		// only the data line is ever driven, and only low
		sda_out_ff <= 1'b0;
		if (bus_stop) begin
			st_ff <= ST_IDLE;
			oe_ff <= 1'b0;
		end else if (bus_start) begin
			// covers the repeated start ahead of a read
			st_ff <= ST_RX;
			ph_ff <= PH_SEL;
			cnt_ff <= 4'h0;
			rd_mode_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			case (st_ff)
			ST_RX: begin
				if (scl_rise) begin
					shift_ff <= {shift_ff[6:0], sda_s_ff};
					cnt_ff <= cnt_ff + 4'h1;
				end else if (scl_fall && cnt_ff == `CPCA_BYTE_BITS) begin
					cnt_ff <= 4'h0;
					case (ph_ff)
					PH_SEL: begin
						if (shift_ff[7:1] == `CPCA_SLAVE_ADDR) begin
							rd_mode_ff <= shift_ff[0];
							ph_ff <= PH_REG;
							oe_ff <= 1'b1;
							st_ff <= ST_ACK;
						end else begin
							st_ff <= ST_IDLE;
						end
					end
					PH_REG: begin
						ptr_ff <= shift_ff;
						ph_ff <= PH_DATA;
						oe_ff <= 1'b1;
						st_ff <= ST_ACK;
					end
					default: begin
						ser_wr_ff <= 1'b1;
						ser_waddr_ff <= ptr_ff;
						ser_wdata_ff <= shift_ff;
						ptr_ff <= ptr_ff + 8'h01;
						oe_ff <= 1'b1;
						st_ff <= ST_ACK;
					end
					endcase
				end
			end
			ST_ACK: begin
				if (scl_fall) begin
					if (rd_mode_ff) begin
						oe_ff <= ~ld_byte[7];
						tx_ff <= {ld_byte[6:0], 1'b0};
						ptr_ff <= ptr_ff + 8'h01;
						cnt_ff <= 4'h1;
						st_ff <= ST_TX;
					end else begin
						oe_ff <= 1'b0;
						cnt_ff <= 4'h0;
						st_ff <= ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_fall) begin
					if (cnt_ff == `CPCA_BYTE_BITS) begin
						oe_ff <= 1'b0;
						st_ff <= ST_RACK;
					end else begin
						oe_ff <= ~tx_ff[7];
						tx_ff <= {tx_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					// a nack ends the read; wait for the stop
					st_ff <= sda_s_ff ? ST_IDLE : ST_ACK;
				end
			end
			default: begin
				oe_ff <= 1'b0;
			end
			endcase
		end
	end
end

// ==========================================================
// coefficient access engine
reg [1:0] op_ff;
reg op_read_ff;
reg mem_we_ff;
reg [COEF_AW-1:0] mem_addr_ff;
reg [COEF_DW-1:0] mem_wdata_ff;
wire [COEF_DW-1:0] mem_rdata;
reg busy_ff;
reg [2:0] grp_ff;
reg [1:0] stage_ff;
reg [2:0] word_ff;

wire ser_ctrl_go = ser_wr_ff && ser_waddr_ff == `CPCA_ADDR_CTRL_LO;
wire lnk_ctrl_go = lnk_wr && lnk_addr == `CPCA_ADDR_CTRL_HI;
wire ser_rst_hit = ser_wr_ff && (ser_waddr_ff == `CPCA_ADDR_RESET_HI ||
	ser_waddr_ff == `CPCA_ADDR_RESET_LO);
wire lnk_rst_hit = lnk_wr && lnk_addr == `CPCA_ADDR_RESET_HI;

// launch uses the control value as it will stand after this write
wire [7:0] go_index = nxt_ctrl[15:8] - `CPCA_INDEX_BASE;
wire go_valid = go_index < `CPCA_COEF_COUNT;
wire go = (ser_ctrl_go | lnk_ctrl_go) & go_valid & ~(ser_rst_hit |
	lnk_rst_hit);

// split an index into its group, stage and word
reg [7:0] rel_idx;
reg [2:0] nxt_grp;
always @* begin
	if (go_index < `CPCA_GRP_REAR) begin
		nxt_grp = `CPCA_G_FRONT;
		rel_idx = go_index;
	end else if (go_index < `CPCA_GRP_SUB) begin
		nxt_grp = `CPCA_G_REAR;
		rel_idx = go_index - `CPCA_GRP_REAR;
	end else if (go_index < `CPCA_GRP_SCALE) begin
		nxt_grp = `CPCA_G_SUB;
		rel_idx = go_index - `CPCA_GRP_SUB;
	end else if (go_index < `CPCA_GRP_REDIR) begin
		nxt_grp = `CPCA_G_SCALE;
		rel_idx = go_index - `CPCA_GRP_SCALE;
	end else begin
		nxt_grp = `CPCA_G_REDIR;
		rel_idx = go_index - `CPCA_GRP_REDIR;
	end
end
wire [7:0] stage_full = rel_idx / `CPCA_WORDS_PER_STAGE;
wire [7:0] word_full = rel_idx % `CPCA_WORDS_PER_STAGE;

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		op_ff <= OP_IDLE;
		op_read_ff <= 1'b0;
		mem_we_ff <= 1'b0;
		mem_addr_ff <= {COEF_AW{1'b0}};
		mem_wdata_ff <= {COEF_DW{1'b0}};
		busy_ff <= 1'b0;
		grp_ff <= `CPCA_G_FRONT;
		stage_ff <= 2'h0;
		word_ff <= 3'h0;
	end else begin
		mem_we_ff <= 1'b0;
		case (op_ff)
		OP_IDLE: begin
			if (go) begin
				op_read_ff <= nxt_ctrl[`CPCA_CTRL_DIR_BIT];
				mem_we_ff <= ~nxt_ctrl[`CPCA_CTRL_DIR_BIT];
				mem_addr_ff <= go_index[COEF_AW-1:0];
				// 20-bit word: top nibble from control, low half from data
				mem_wdata_ff <= {nxt_ctrl[`CPCA_CTRL_TOP_MSB:0],
					nxt_data_low};
				busy_ff <= 1'b1;
				grp_ff <= nxt_grp;
				stage_ff <= (nxt_grp <= `CPCA_G_SUB) ?
					stage_full[1:0] : 2'h0;
				word_ff <= (nxt_grp <= `CPCA_G_SUB) ?
					word_full[2:0] : rel_idx[2:0];
				op_ff <= OP_WAIT;
			end
		end
		OP_WAIT: begin
			op_ff <= OP_CAPT;
		end
		default: begin
			busy_ff <= 1'b0;
			op_ff <= OP_IDLE;
		end
		endcase
	end
end

cpca_coef_mem #(
	.DEPTH(69),
	.AW(COEF_AW),
	.DW(COEF_DW)
) u_coef_mem (
	.mclk(mclk),
	.we(mem_we_ff),
	.addr(mem_addr_ff),
	.wdata(mem_wdata_ff),
	.rdata(mem_rdata)
);

wire rd_capture = op_ff == OP_CAPT && op_read_ff;

// ==========================================================
// register writes from both paths
always @* begin
	nxt_data_low = data_low_ff;
	nxt_ctrl = ctrl_ff;
	if (rd_capture) begin
		nxt_data_low = mem_rdata[15:0];
		nxt_ctrl[`CPCA_CTRL_TOP_MSB:0] = mem_rdata[COEF_DW-1:16];
	end
	if (lnk_wr) begin
		case (lnk_addr)
		`CPCA_ADDR_DATA_HI: nxt_data_low = lnk_wdata;
		`CPCA_ADDR_CTRL_HI: nxt_ctrl = lnk_wdata;
		default: nxt_ctrl = nxt_ctrl;
		endcase
	end
	if (ser_wr_ff) begin
		case (ser_waddr_ff)
		`CPCA_ADDR_DATA_HI: nxt_data_low[15:8] = ser_wdata_ff;
		`CPCA_ADDR_DATA_LO: nxt_data_low[7:0] = ser_wdata_ff;
		`CPCA_ADDR_CTRL_HI: nxt_ctrl[15:8] = ser_wdata_ff;
		`CPCA_ADDR_CTRL_LO: nxt_ctrl[7:0] = ser_wdata_ff;
		default: nxt_ctrl = nxt_ctrl;
		endcase
	end
	if (ser_rst_hit || lnk_rst_hit) begin
		nxt_data_low = `CPCA_DATA_RST;
		nxt_ctrl = `CPCA_CTRL_RST;
	end
end

always @(posedge mclk or posedge rst) begin
	if (rst) begin
		data_low_ff <= `CPCA_DATA_RST;
		ctrl_ff <= `CPCA_CTRL_RST;
		regs_reset_ff <= 1'b0;
		lnk_rdata_ff <= 16'h0000;
	end else begin
		data_low_ff <= nxt_data_low;
		ctrl_ff <= nxt_ctrl;
		// tells the rest of the chip to reload its own defaults
		regs_reset_ff <= ser_rst_hit | lnk_rst_hit;
		case (lnk_addr)
		`CPCA_ADDR_RESET_HI: lnk_rdata_ff <= ID_CODE;
		`CPCA_ADDR_DATA_HI: lnk_rdata_ff <= data_low_ff;
		`CPCA_ADDR_CTRL_HI: lnk_rdata_ff <= ctrl_ff;
		default: lnk_rdata_ff <= 16'h0000;
		endcase
	end
end

// ==========================================================
// outputs
assign sda_out = sda_out_ff;
assign sda_oe = oe_ff;
assign lnk_rdata = lnk_rdata_ff;
assign regs_reset = regs_reset_ff;
assign coef_busy = busy_ff;
assign coef_group = grp_ff;
assign coef_stage = stage_ff;
assign coef_word = word_ff;

endmodule // cpca_top

// File: verilog/cpca_defs.vh
// Summary of operation
// - device is only a bus target; never starts transfers nor drives clock
// - each 16-bit register is two bytes: high byte even, low byte odd
// - data line changes only with clock low; else start or stop
// - falling data with clock high is start; rising is stop
// - sender releases data after 8 bits; receiver pulls low on ninth
// - device samples the data line on each rising serial clock edge
// - select byte msb first; device answers only to address 0011110
// - select lsb: one read, zero write; acknowledge on ninth bit
// - write transfer: byte after select is register byte address, acked
// - single byte write: one data byte, acknowledged, then master stop
// - multi-byte write starts anywhere, runs until master stop
// - serial read: address, direction at 7Bh, then read 78h, 79h, 7Bh
// - serial write: 78h, 79h, address at 7Ah, then 7Bh with top bits
// - memory access starts only on write of byte 7Bh or link 7Ah
// - link read: write 7Ah with direction, read 78h and 7Ah nibble
// - link write: 78h first, then 7Ah with index, direction, top bits
// - coefficient indices 0 to 68 in groups of 20,20,20,3,6
// - four stages per front, rear and sub group, five words each, stage number 0..3; scale and redirection use stage 0
// - filter coefficients are 20-bit two's complement values
// - scale and redirection factors are 20-bit, minus one to zero
// - any write to address 00h returns control registers to defaults
// - read of address zero returns a fixed identification code
`ifndef CPCA_DEFS_VH
`define CPCA_DEFS_VH

// ==========================================================
// serial bus
`define CPCA_SLAVE_ADDR 7'h1e
`define CPCA_BYTE_BITS 4'h8

// ==========================================================
// byte and word offsets
`define CPCA_ADDR_RESET_HI 8'h00
`define CPCA_ADDR_RESET_LO 8'h01
`define CPCA_ADDR_DATA_HI 8'h78
`define CPCA_ADDR_DATA_LO 8'h79
`define CPCA_ADDR_CTRL_HI 8'h7a
`define CPCA_ADDR_CTRL_LO 8'h7b

// ==========================================================
// field layout of coefficient_index_control
`define CPCA_CTRL_DIR_BIT 7
`define CPCA_CTRL_TOP_MSB 3
`define CPCA_INDEX_BASE 8'h40

// ==========================================================
// reset values
`define CPCA_DATA_RST 16'h0000
`define CPCA_CTRL_RST 16'h0000

// ==========================================================
// coefficient map
`define CPCA_COEF_COUNT 8'h45
`define CPCA_GRP_REAR 8'h14
`define CPCA_GRP_SUB 8'h28
`define CPCA_GRP_SCALE 8'h3c
`define CPCA_GRP_REDIR 8'h3f
`define CPCA_WORDS_PER_STAGE 8'h05
`define CPCA_WORDS_PER_GROUP 8'h14

// ==========================================================
// group codes
`define CPCA_G_FRONT 3'h0
`define CPCA_G_REAR 3'h1
`define CPCA_G_SUB 3'h2
`define CPCA_G_SCALE 3'h3
`define CPCA_G_REDIR 3'h4

`endif

// File: verilog/cpca_coef_mem.v
`timescale 1ns/1ps
// ==========================================================
// coefficient memory: one port, registered read data
module cpca_coef_mem #(
	parameter DEPTH = 69,
	parameter AW = 7,
	parameter DW = 20
) (
	// clock
	input wire mclk,
	// access
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata
);

reg [DW-1:0] mem [0:DEPTH-1];

always @(posedge mclk) begin
	if (we) begin
		mem[addr] <= wdata;
	end
	rdata <= mem[addr];
end

endmodule // cpca_coef_mem

// File: tb/cpca_top_sva.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the control port
module cpca_top_sva #(
	parameter [15:0] ID_CODE = 16'h5a5a // arbitrary identification value
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// serial bus
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	// link port
	input wire lnk_wr,
	input wire [7:0] lnk_addr,
	input wire [15:0] lnk_wdata,
	input wire [15:0] lnk_rdata,
	// status
	input wire regs_reset,
	input wire coef_busy,
	input wire [2:0] coef_group,
	input wire [1:0] coef_stage,
	input wire [2:0] coef_word
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire launch = lnk_wr && lnk_addr == 8'h7a && !coef_busy
		&& lnk_wdata[15:8] >= 8'h40 && lnk_wdata[15:8] <= 8'h84;

	a_sda_never_high: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_oe_clock_high: assert property (scl_in && $past(scl_in, 3) |-> $stable(sda_oe))
		else $error("data line moved with clock high");
	a_oe_whole_bit: assert property ($rose(sda_oe) |-> sda_oe[*6])
		else $error("low drive too short");
	a_launch_busy: assert property (launch |=> coef_busy)
		else $error("launch not started");
	a_data_no_launch: assert property (lnk_wr && lnk_addr == 8'h78 && !coef_busy |=> !coef_busy)
		else $error("data write started access");
	a_busy_bounded: assert property ($rose(coef_busy) |-> ##[1:4] !coef_busy)
		else $error("access too long");
	a_reset_pulse: assert property (lnk_wr && lnk_addr == 8'h00 |-> ##[1:2] regs_reset)
		else $error("no register reset");
	a_reset_single: assert property (regs_reset |=> !regs_reset)
		else $error("reset pulse too long");
	a_id_read: assert property (lnk_addr == 8'h00 |=> lnk_rdata == ID_CODE)
		else $error("wrong identification");
	a_group_map: assert property (coef_group <= 3'h4 && (coef_group < 3'h3 ? coef_word <= 3'h4 : coef_stage == 2'h0))
		else $error("bad group decode");

	c_launch: cover property (launch);
	c_reset: cover property ($rose(regs_reset));
	c_ack: cover property ($rose(sda_oe));
endmodule // cpca_top_sva

bind cpca_top cpca_top_sva #(.ID_CODE(ID_CODE)) i_sva (.mclk, .rst,
	.scl_in, .sda_in, .sda_out, .sda_oe, .lnk_wr, .lnk_addr, .lnk_wdata,
	.lnk_rdata, .regs_reset, .coef_busy, .coef_group, .coef_stage,
	.coef_word);

// File: tb/cpca_i2c_master.sv
`timescale 1ns/1ps
// ==========================================================
// bus master model; clock stands high between frames
module cpca_i2c_master (
	// bus wires
	output logic scl,
	output logic sda_m,
	input wire sda
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// also serves as repeated start
	task start;
		begin
			// let the target drop its acknowledge before the clock rises
			#200 sda_m = 1'b1;
			#200 scl = 1'b1;
			#200 sda_m = 1'b0;
			#200 scl = 1'b0;
		end
	endtask
	// data only moves in the low phase, sampled mid high phase
	task bit_io(input logic b, output logic r);
		begin
			scl = 1'b0;
			#200 sda_m = b;
			#200 scl = 1'b1;
			#200 r = sda;
			#200 scl = 1'b0;
		end
	endtask
	task wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		begin
			for (int i = 7; i >= 0; i--) bit_io(d[i], r);
			bit_io(1'b1, r);
			ack = ~r;
		end
	endtask
	// last byte is answered with a release, i.e. no acknowledge
	task rd_byte(input logic last, output logic [7:0] d);
		logic r;
		begin
			for (int i = 7; i >= 0; i--) begin
				bit_io(1'b1, r);
				d[i] = r;
			end
			bit_io(last, r);
		end
	endtask
	task stop;
		begin
			scl = 1'b0;
			#200 sda_m = 1'b0;
			#200 scl = 1'b1;
			#200 sda_m = 1'b1;
			#400;
		end
	endtask
endmodule // cpca_i2c_master

// File: tb/cpca_top_tb.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the control port
module cpca_top_tb;
	localparam [15:0] ID = 16'h5a3c; // arbitrary value
	logic mclk;
	logic rst;
	logic lnk_wr;
	logic [7:0] lnk_addr;
	logic [15:0] lnk_wdata;
	wire [15:0] lnk_rdata;
	wire scl, sda_m, sda, sda_out, sda_oe, regs_reset, coef_busy;
	wire [2:0] coef_group;
	wire [1:0] coef_stage;
	wire [2:0] coef_word;
	int errors;
	int checks;
	logic [15:0] rd;
	logic ack;
	// pull-up on the data wire
	assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
	cpca_top #(.ID_CODE(ID)) i_dut (.mclk, .rst, .scl_in(scl),
		.sda_in(sda), .sda_out, .sda_oe, .lnk_wr, .lnk_addr, .lnk_wdata,
		.lnk_rdata, .regs_reset, .coef_busy, .coef_group, .coef_stage,
		.coef_word);
	cpca_i2c_master i_master (.scl(scl), .sda_m(sda_m), .sda(sda));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ==========================================================
	// shared tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks++;
			if (got !== exp) begin
				errors++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task summarize;
		begin
			$display("checks=%0d errors=%0d", checks, errors);
			if (errors == 0 && checks > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask
	task l_wr(input logic [7:0] a, input logic [15:0] d);
		begin
			@(posedge mclk) #1;
			lnk_addr = a;
			lnk_wdata = d;
			lnk_wr = 1'b1;
			@(posedge mclk) #1;
			lnk_wr = 1'b0;
		end
	endtask
	task l_rd(input logic [7:0] a, output logic [15:0] d);
		begin
			@(posedge mclk) #1;
			lnk_addr = a;
			repeat (2) @(posedge mclk);
			#1 d = lnk_rdata;
		end
	endtask
	task wait_idle;
		int n;
		begin
			n = 0;
			@(posedge mclk) #1;
			while (coef_busy !== 1'b0 && n < 20) begin
				@(posedge mclk) #1;
				n++;
			end
			check(coef_busy, 1'b0);
		end
	endtask
	// high byte goes first
	task s_wr(input logic [7:0] ra, input logic [15:0] d, input int n);
		begin
			i_master.start();
			i_master.wr_byte(8'h3c, ack);
			check(ack, 1'b1);
			i_master.wr_byte(ra, ack);
			check(ack, 1'b1);
			for (int i = 0; i < n; i++) begin
				i_master.wr_byte(d[15-8*i -: 8], ack);
				check(ack, 1'b1);
			end
			i_master.stop();
		end
	endtask
	task s_rd(input logic [7:0] ra, input int n, output logic [15:0] d);
		logic [7:0] b;
		begin
			d = 16'h0000;
			i_master.start();
			i_master.wr_byte(8'h3c, ack);
			i_master.wr_byte(ra, ack);
			i_master.start();
			i_master.wr_byte(8'h3d, ack);
			check(ack, 1'b1);
			for (int i = 0; i < n; i++) begin
				i_master.rd_byte(i == n - 1, b);
				d = {d[7:0], b};
			end
			i_master.stop();
		end
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		begin
			l_rd(8'h78, rd);
			check(rd, 16'h0000);
			l_rd(8'h7a, rd);
			check(rd, 16'h0000);
			l_rd(8'h00, rd);
			check(rd, ID);
			$display("end reset test");
		end
	endtask
	task t_serial;
		begin
			s_wr(8'h78, 16'h12c3, 2);
			l_rd(8'h78, rd);
			check(rd, 16'h12c3);
			s_wr(8'h79, 16'h7e00, 1);
			s_rd(8'h78, 2, rd);
			check(rd, 16'h127e);
			s_rd(8'h00, 2, rd);
			check(rd, ID);
			i_master.start();
			i_master.wr_byte(8'h3e, ack);
			check(ack, 1'b0);
			i_master.stop();
			$display("end serial test");
		end
	endtask
	task t_coef_link;
		begin
			l_wr(8'h78, 16'hbeef);
			check(coef_busy, 1'b0);
			l_wr(8'h7a, 16'h8405);
			wait_idle();
			l_wr(8'h78, 16'h0000);
			l_wr(8'h7a, 16'h8480);
			wait_idle();
			check({coef_group, coef_stage, coef_word}, 8'h85);
			l_rd(8'h78, rd);
			check(rd, 16'hbeef);
			l_rd(8'h7a, rd);
			check(rd[3:0], 4'h5);
			l_wr(8'h7a, 16'h8580);
			check(coef_busy, 1'b0);
			$display("end link coefficient test");
		end
	endtask
	task t_coef_serial;
		begin
			s_wr(8'h78, 16'h0123, 2);
			s_wr(8'h7a, 16'h5b09, 2);
			wait_idle();
			s_wr(8'h78, 16'h0000, 2);
			s_wr(8'h7a, 16'h5b80, 2);
			wait_idle();
			check({coef_group, coef_stage, coef_word}, 8'h2a);
			s_rd(8'h78, 2, rd);
			check(rd, 16'h0123);
			s_rd(8'h7b, 1, rd);
			check(rd[3:0], 4'h9);
			$display("end serial coefficient test");
		end
	endtask
	task t_soft_reset;
		begin
			l_wr(8'h78, 16'hffff);
			s_wr(8'h00, 16'h0000, 1);
			l_rd(8'h78, rd);
			check(rd, 16'h0000);
			l_wr(8'h7a, 16'h1234);
			l_wr(8'h00, 16'h0000);
			check(regs_reset, 1'b1);
			l_rd(8'h7a, rd);
			check(rd, 16'h0000);
			$display("end register reset test");
		end
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		errors = 0;
		checks = 0;
		rst = 1'b1;
		lnk_wr = 1'b0;
		lnk_addr = 8'h00;
		lnk_wdata = 16'h0000;
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		t_reset();
		t_serial();
		t_coef_link();
		t_coef_serial();
		t_soft_reset();
		summarize();
	end
	// tests need about 0.36 ms
	initial begin
		#2000000;
		errors++;
		summarize();
	end
endmodule // cpca_top_tb
